/* seser_defs.svh */
// Offsets-free constants for the standard event status block
`ifndef SESER_DEFS_SVH
`define SESER_DEFS_SVH
`define SESER_BIT_PWR_ON 7
`define SESER_BIT_USER_REQ 6
`define SESER_BIT_PARSE_ERR 5
`define SESER_BIT_EXEC_ERR 4
`define SESER_BIT_DEV_ERR 3
`define SESER_BIT_QUERY_ERR 2
`define SESER_BIT_REQ_CTRL 1
`define SESER_BIT_OP_DONE 0
`define SESER_SUMMARY_BIT 5
`define SESER_FLAGS_RESET 8'h80
`define SESER_MASK_RESET 8'h00
`define SESER_CODE_RESET 8'h00
`define SESER_DEVERR_RESET 16'h0000
`define SESER_EXR_LOCAL 8'h15
`define SESER_EXR_PARAMS 8'h19
`define SESER_EXR_UNIMPL 8'h1A
`endif

/* seser_pkg.sv */
// Types shared by the standard event status block
package seser_pkg;
    typedef enum logic [3:0] {
        SESER_OP_SET_MASK = 4'h0,
        SESER_OP_GET_MASK = 4'h1,
        SESER_OP_GET_FLAGS = 4'h2,
        SESER_OP_GET_EXEC = 4'h3,
        SESER_OP_GET_PARSE = 4'h4,
        SESER_OP_GET_KEY = 4'h5,
        SESER_OP_GET_DEVERR = 4'h6,
        SESER_OP_OP_DONE = 4'h7
    } seser_op_t;

    typedef struct packed {
        seser_op_t op;
        logic [7:0] value;
    } seser_cmd_t;

    typedef struct packed {
        logic parse_err;
        logic [7:0] parse_code;
        logic exec_err;
        logic [7:0] exec_code;
        logic dev_err;
        logic [15:0] dev_code;
        logic [4:0] query_err;
    } seser_evt_t;

    typedef enum logic [1:0] {
        SESER_ST_IDLE = 2'b01,
        SESER_ST_REPLY = 2'b10
    } seser_state_t;
endpackage

/* seser_sync.sv */
// Two-flop synchroniser with rising-edge pulse for a pin input
module seser_sync (
    input wire logic i_clk,    // Device clock
    input wire logic i_nrst,   // Async reset, active low
    input wire logic i_pin,    // Asynchronous pin level
    output logic o_level,      // Synchronised level
    output logic o_rise        // One-cycle pulse on rising edge
);
    logic meta_ff;
    logic sync_ff;
    logic last_ff;

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
            last_ff <= 1'b0;
        end
        else
        begin
            meta_ff <= i_pin;
            sync_ff <= meta_ff;
            last_ff <= sync_ff;
        end
    end

    assign o_level = sync_ff;
    assign o_rise = sync_ff & ~last_ff;
endmodule

/* seser_status.sv */
// Standard event status reporting: flags, enable mask and error code registers
//
// Contract
// - Mask 0..255 gates summary; query returns mask
// - Flags query returns bits 0..7, then clears
// - Bits 15..8 of flags read zero
// - Power-on flag set at every power-up
// - Soft key sets user flag, key recorded
// - Syntax error sets parse flag, code kept
// - Execution error sets flag, code stored
// - Hardware failure sets device error flag
// - Any query fault condition sets query flag
// - Request-control flag always reads zero
// - Operation-complete command sets its flag
// - One command at a time, strictly ordered
// - Execution code query returns, then clears
// - Execution code reads zero when clean
// - Codes 21, 25, 26 for execution faults
// - Device error code 0..65535, clear on read
`include "seser_defs.svh"

module seser_status (
    input wire logic i_clk,                     // Device clock, 25 MHz
    input wire logic i_nrst,                    // Async reset, active low
    input wire logic i_cmd_valid,               // Command offered
    input wire seser_pkg::seser_cmd_t i_cmd,    // Command opcode and value
    output logic o_cmd_ready,                   // Command accepted when high
    output logic o_rsp_valid,                   // Reply available
    output logic [15:0] o_rsp_data,             // Reply value
    input wire logic i_rsp_ready,               // Controller takes reply
    input wire seser_pkg::seser_evt_t i_evt,    // Same-clock event strobes
    input wire logic i_key_pin,                 // Soft key press pin, async
    input wire logic [7:0] i_key_code_pin,      // Key number, stable with press
    output logic o_local_mode_refused,          // Pulse: command refused locally
    input wire logic i_local_mode,              // Instrument in local state
    output logic o_event_summary,               // Summary bit of status byte
    output logic [7:0] o_status_byte            // Status byte, only summary bit owned
);
    seser_pkg::seser_state_t state_ff;
    seser_pkg::seser_state_t nxt_state;
    logic [7:0] flags_ff;
    logic [7:0] nxt_flags;
    logic [7:0] mask_ff;
    logic [7:0] exec_code_ff;
    logic [7:0] nxt_exec_code;
    logic [7:0] parse_code_ff;
    logic [7:0] nxt_parse_code;
    logic [7:0] key_ff;
    logic [15:0] dev_code_ff;
    logic [15:0] nxt_dev_code;
    logic [15:0] rsp_ff;
    logic [15:0] nxt_rsp;
    logic refused_ff;
    logic [7:0] key_meta_ff;
    logic [7:0] key_sync_ff;
    logic key_rise;
    logic local_meta_ff;
    logic local_sync_ff;

    // Same synchroniser used for the key press; code bus sampled twice too
    seser_sync u_key_sync (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_pin(i_key_pin),
        .o_level(),
        .o_rise(key_rise)
    );

    function automatic logic [15:0] widen8(input logic [7:0] v);
        widen8 = {8'h00, v};
    endfunction

    wire take = i_cmd_valid & o_cmd_ready;
    wire [3:0] op = i_cmd.op;
    wire is_set_mask = take & (op == seser_pkg::SESER_OP_SET_MASK);
    wire is_get_mask = take & (op == seser_pkg::SESER_OP_GET_MASK);
    wire is_get_flags = take & (op == seser_pkg::SESER_OP_GET_FLAGS);
    wire is_get_exec = take & (op == seser_pkg::SESER_OP_GET_EXEC);
    wire is_get_parse = take & (op == seser_pkg::SESER_OP_GET_PARSE);
    wire is_get_key = take & (op == seser_pkg::SESER_OP_GET_KEY);
    wire is_get_dev = take & (op == seser_pkg::SESER_OP_GET_DEVERR);
    wire is_op_done = take & (op == seser_pkg::SESER_OP_OP_DONE);
    wire is_known = is_set_mask | is_get_mask | is_get_flags | is_get_exec
        | is_get_parse | is_get_key | is_get_dev | is_op_done;
    // Mask write is a remote setting, refused while in local state
    wire refuse_local = is_set_mask & local_sync_ff;
    wire bad_op = take & ~is_known;
    wire int_exec_err = refuse_local | bad_op;
    wire [7:0] int_exec_code = refuse_local ? `SESER_EXR_LOCAL : `SESER_EXR_UNIMPL;
    // Set-mask carries its value; a query with a nonzero value has one parameter too many
    wire extra_param = take & ~is_set_mask & is_known & (i_cmd.value != 8'h00);
    wire any_exec_err = i_evt.exec_err | int_exec_err | extra_param;

    wire [7:0] set_bits = {
        1'b0,
        key_rise,
        i_evt.parse_err,
        any_exec_err,
        i_evt.dev_err,
        |i_evt.query_err,
        1'b0,
        is_op_done
    };

    // Read-clear loses no event: set bits are OR'd after the clear
    assign nxt_flags = ((is_get_flags ? 8'h00 : flags_ff) | set_bits) & 8'hFD;

    always_comb
    begin
        nxt_exec_code = is_get_exec ? `SESER_CODE_RESET : exec_code_ff;
        if (i_evt.exec_err)
        begin
            nxt_exec_code = i_evt.exec_code;
        end
        else if (int_exec_err)
        begin
            nxt_exec_code = int_exec_code;
        end
        else if (extra_param)
        begin
            nxt_exec_code = `SESER_EXR_PARAMS;
        end
    end

    assign nxt_parse_code = i_evt.parse_err ? i_evt.parse_code : parse_code_ff;
    assign nxt_dev_code = i_evt.dev_err ? i_evt.dev_code
        : (is_get_dev ? `SESER_DEVERR_RESET : dev_code_ff);

    always_comb
    begin
        nxt_rsp = rsp_ff;
        if (is_get_mask)
        begin
            nxt_rsp = widen8(mask_ff);
        end
        else if (is_get_flags)
        begin
            nxt_rsp = widen8(flags_ff);
        end
        else if (is_get_exec)
        begin
            nxt_rsp = widen8(exec_code_ff);
        end
        else if (is_get_parse)
        begin
            nxt_rsp = widen8(parse_code_ff);
        end
        else if (is_get_key)
        begin
            nxt_rsp = widen8(key_ff);
        end
        else if (is_get_dev)
        begin
            nxt_rsp = dev_code_ff;
        end
        else if (take)
        begin
            nxt_rsp = 16'h0000;
        end
    end

    // Every command answers once; no new command until the answer is taken
    always_comb
    begin
        case (state_ff)
            seser_pkg::SESER_ST_IDLE:
            begin
                nxt_state = take ? seser_pkg::SESER_ST_REPLY : seser_pkg::SESER_ST_IDLE;
            end
            seser_pkg::SESER_ST_REPLY:
            begin
                nxt_state = i_rsp_ready ? seser_pkg::SESER_ST_IDLE : seser_pkg::SESER_ST_REPLY;
            end
            default:
            begin
                nxt_state = seser_pkg::SESER_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            state_ff <= seser_pkg::SESER_ST_IDLE;
            flags_ff <= `SESER_FLAGS_RESET;
            mask_ff <= `SESER_MASK_RESET;
            exec_code_ff <= `SESER_CODE_RESET;
            parse_code_ff <= `SESER_CODE_RESET;
            key_ff <= `SESER_CODE_RESET;
            dev_code_ff <= `SESER_DEVERR_RESET;
            rsp_ff <= 16'h0000;
            refused_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            flags_ff <= nxt_flags;
            exec_code_ff <= nxt_exec_code;
            parse_code_ff <= nxt_parse_code;
            dev_code_ff <= nxt_dev_code;
            rsp_ff <= nxt_rsp;
            refused_ff <= refuse_local;
            if (is_set_mask & ~local_sync_ff)
            begin
                mask_ff <= i_cmd.value;
            end
            if (key_rise)
            begin
                key_ff <= key_sync_ff;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            key_meta_ff <= 8'h00;
            key_sync_ff <= 8'h00;
            local_meta_ff <= 1'b0;
            local_sync_ff <= 1'b0;
        end
        else
        begin
            key_meta_ff <= i_key_code_pin;
            key_sync_ff <= key_meta_ff;
            local_meta_ff <= i_local_mode;
            local_sync_ff <= local_meta_ff;
        end
    end

    assign o_cmd_ready = (state_ff == seser_pkg::SESER_ST_IDLE);
    assign o_rsp_valid = (state_ff == seser_pkg::SESER_ST_REPLY);
    assign o_rsp_data = rsp_ff;
    assign o_local_mode_refused = refused_ff;
    assign o_event_summary = |(flags_ff & mask_ff);
    assign o_status_byte = {2'b00, o_event_summary, 5'b00000};
endmodule

/* seser_status_assertions.sv */
// Concurrent checks on the ports of the standard event status block
module seser_status_assertions (
    input wire logic i_clk, // Clock
    input wire logic i_nrst, // Reset, low
    input wire logic i_cmd_valid, // Offer
    input wire seser_pkg::seser_cmd_t i_cmd, // Command
    input wire logic o_cmd_ready, // Ready
    input wire logic o_rsp_valid, // Reply
    input wire logic [15:0] o_rsp_data, // Data
    input wire logic i_rsp_ready, // Taken
    input wire seser_pkg::seser_evt_t i_evt, // Events
    input wire logic i_local_mode, // Local
    input wire logic o_local_mode_refused, // Refused
    input wire logic o_event_summary, // Summary
    input wire logic [7:0] o_status_byte // Status
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_nrst);
    wire take = i_cmd_valid && o_cmd_ready;
    sequence s_take(logic [3:0] code);
        take && i_cmd.op == code;
    endsequence
    a_reply_follows: assert property (take |=> o_rsp_valid)
        else $error("no reply after command");
    a_busy_refuses: assert property (o_rsp_valid |-> !o_cmd_ready)
        else $error("ready while reply pending");
    a_reply_holds: assert property (o_rsp_valid && !i_rsp_ready |=> o_rsp_valid && $stable(o_rsp_data))
        else $error("reply dropped early");
    a_reply_release: assert property (o_rsp_valid && i_rsp_ready |=> !o_rsp_valid)
        else $error("reply not released");
    a_flags_reserved: assert property (s_take(4'h2) |=> o_rsp_data[15:8] == 8'h00 && !o_rsp_data[1])
        else $error("reserved flag bits set");
    a_status_only: assert property (o_status_byte == {2'b00, o_event_summary, 5'b00000})
        else $error("status byte wrong");
    a_read_clears: assert property (s_take(4'h2) ##0 i_evt == '0 |=> !o_event_summary)
        else $error("flags not cleared");
    a_exec_flagged: assert property (i_evt.exec_err ##2 s_take(4'h2) |=> o_rsp_data[4])
        else $error("exec flag missing");
    a_local_refused: assert property (i_local_mode [*4] ##0 s_take(4'h0) |=> o_local_mode_refused)
        else $error("local refusal missing");
endmodule

/* seser_ctrl_model.sv */
// Remote controller model that takes replies promptly or after a stall
module seser_ctrl_model (
    input wire logic i_clk, // Clock
    input wire logic i_nrst, // Reset, low
    input wire logic i_rsp_valid, // Reply offered
    input wire logic [3:0] i_delay, // Stall cycles
    output logic o_rsp_ready // Reply taken
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] wait_ff;
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            wait_ff <= 4'h0;
        else if (o_rsp_ready || !i_rsp_valid)
            wait_ff <= 4'h0;
        else
            wait_ff <= wait_ff + 4'h1;
    end
    // Stalling proves the device holds its reply
    assign o_rsp_ready = i_rsp_valid && (wait_ff >= i_delay);
endmodule

/* seser_status_bench.sv */
// Self-checking bench for the standard event status block
module seser_status_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk = 1'b0;
    logic i_nrst = 1'b0;
    logic i_cmd_valid = 1'b0;
    seser_pkg::seser_cmd_t i_cmd = '0;
    seser_pkg::seser_evt_t i_evt = '0;
    logic i_key_pin = 1'b0;
    logic [7:0] i_key_code_pin = 8'h00;
    logic i_local_mode = 1'b0;
    logic [3:0] delay = 4'h0;
    logic i_rsp_ready, o_cmd_ready, o_rsp_valid, o_local_mode_refused, o_event_summary;
    logic [15:0] o_rsp_data, rd;
    logic [7:0] o_status_byte;
    int err_count = 0;
    int checks_done = 0;
    int refusals = 0;
    always #20 i_clk = ~i_clk;
    // Refusal pulse stands one cycle, so count it where it stands
    always @(negedge i_clk)
        if (o_local_mode_refused === 1'b1)
            refusals <= refusals + 1;
    seser_status dut (.i_clk, .i_nrst, .i_cmd_valid, .i_cmd, .o_cmd_ready, .o_rsp_valid, .o_rsp_data,
        .i_rsp_ready, .i_evt, .i_key_pin, .i_key_code_pin, .o_local_mode_refused, .i_local_mode,
        .o_event_summary, .o_status_byte);
    seser_ctrl_model partner (.i_clk, .i_nrst, .i_rsp_valid(o_rsp_valid), .i_delay(delay),
        .o_rsp_ready(i_rsp_ready));
    task automatic end_sim;
        $display("errors %0d checks %0d", err_count, checks_done);
        if (err_count == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            err_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // Request held until the edge that samples ready
    task automatic cmd(input logic [3:0] op, input logic [7:0] val);
        int n;
        n = 0;
        @(posedge i_clk);
        i_cmd_valid <= 1'b1;
        i_cmd <= {op, val};
        do @(negedge i_clk); while (o_cmd_ready !== 1'b1 && ++n < 20);
        @(posedge i_clk);
        i_cmd_valid <= 1'b0;
        do @(negedge i_clk); while (!(o_rsp_valid === 1'b1 && i_rsp_ready === 1'b1) && ++n < 40);
        if (n >= 40)
        begin
            err_count++;
            end_sim();
        end
        else
            rd = o_rsp_data;
    endtask
    task automatic q(input logic [3:0] op, input logic [7:0] val, input logic [15:0] exp);
        cmd(op, val);
        check($sformatf("reply op %0h", op), rd, exp);
    endtask
    // Strobe one event, check summary, then read flags back
    task automatic ev(input seser_pkg::seser_evt_t e, input logic [15:0] w, input logic s);
        @(posedge i_clk);
        i_evt <= e;
        @(posedge i_clk);
        i_evt <= '0;
        @(negedge i_clk);
        check("summary", o_event_summary, s);
        check("status byte", o_status_byte, {s, 5'h00});
        q(4'h2, 8'h00, w);
    endtask
    initial
    begin
        repeat (20) @(posedge i_clk);
        i_nrst <= 1'b1;
        q(4'h2, 8'h00, 16'h0080);
        q(4'h2, 8'h00, 16'h0000);
        q(4'h3, 8'h00, 16'h0000);
        cmd(4'h0, 8'hFF);
        q(4'h1, 8'h00, 16'h00FF);
        ev('{1'b1, 8'h3C, 1'b0, 8'h00, 1'b0, 16'h0000, 5'h00}, 16'h0020, 1'b1);
        q(4'h4, 8'h00, 16'h003C);
        ev('{1'b0, 8'h00, 1'b1, 8'h2A, 1'b0, 16'h0000, 5'h00}, 16'h0010, 1'b1);
        q(4'h3, 8'h00, 16'h002A);
        q(4'h3, 8'h00, 16'h0000);
        ev('{1'b0, 8'h00, 1'b0, 8'h00, 1'b1, 16'hBEEF, 5'h00}, 16'h0008, 1'b1);
        q(4'h6, 8'h00, 16'hBEEF);
        q(4'h6, 8'h00, 16'h0000);
        for (int i = 0; i < 5; i++)
            ev('{1'b0, 8'h00, 1'b0, 8'h00, 1'b0, 16'h0000, 5'(1 << i)}, 16'h0004, 1'b1);
        @(posedge i_clk);
        i_key_code_pin <= 8'h5A;
        i_key_pin <= 1'b1;
        repeat (5) @(posedge i_clk);
        i_key_pin <= 1'b0;
        q(4'h2, 8'h00, 16'h0040);
        q(4'h5, 8'h00, 16'h005A);
        q(4'h7, 8'h00, 16'h0000);
        q(4'h2, 8'h00, 16'h0001);
        cmd(4'h0, 8'h08);
        delay <= 4'h3;
        ev('{1'b0, 8'h00, 1'b1, 8'h01, 1'b0, 16'h0000, 5'h00}, 16'h0010, 1'b0);
        @(posedge i_clk);
        i_local_mode <= 1'b1;
        repeat (4) @(posedge i_clk);
        cmd(4'h0, 8'h00);
        check("refusals", 16'(refusals), 16'h0001);
        @(posedge i_clk);
        i_local_mode <= 1'b0;
        q(4'h1, 8'h00, 16'h0008);
        q(4'h3, 8'h00, 16'h0015);
        q(4'h1, 8'h01, 16'h0008);
        q(4'h3, 8'h00, 16'h0019);
        cmd(4'hF, 8'h00);
        q(4'h3, 8'h00, 16'h001A);
        @(posedge i_clk);
        i_nrst <= 1'b0;
        repeat (3) @(posedge i_clk);
        i_nrst <= 1'b1;
        q(4'h2, 8'h00, 16'h0080);
        q(4'h1, 8'h00, 16'h0000);
        check("refusals", 16'(refusals), 16'h0001);
        end_sim();
    end
endmodule
bind seser_status seser_status_assertions chk (.i_clk, .i_nrst, .i_cmd_valid, .i_cmd, .o_cmd_ready, .o_rsp_valid,
    .o_rsp_data, .i_rsp_ready, .i_evt, .i_local_mode, .o_local_mode_refused, .o_event_summary, .o_status_byte);
